// ### pox_xlate_map.vh
// Register map, field positions and reset values of the outbound window block
`ifndef POX_XLATE_MAP_VH
`define POX_XLATE_MAP_VH

// Register offsets (byte addresses)
`define POX_OFS_GCTL       12'hD68
`define POX_OFS_MV_RD      12'hD6C
`define POX_OFS_MV_WR      12'hD70
`define POX_OFS_SUB1       12'hD74
`define POX_OFS_SUB2       12'hD78
`define POX_OFS_CMDCTL     12'hD7C

// Reset values
`define POX_RST_GCTL       32'h0800_0000
`define POX_RST_MV         32'h0000_0000
`define POX_RST_SUB        32'h0000_0000
`define POX_RST_CMDCTL     32'h0000_0000

// Global control bits (bit 0 is the msb in the printed layout)
`define POX_GCTL_RST       27
`define POX_GCTL_CFGMSB    26
`define POX_GCTL_NOPOST    25
`define POX_GCTL_NOLAT     24
`define POX_GCTL_MASK      32'h0F00_0000

// Mask/value fields
`define POX_MV_W1_MASK     31:24
`define POX_MV_W1_VAL      23:16
`define POX_MV_W2_MASK     15:8
`define POX_MV_W2_VAL      7:0

// Subwindow fields
`define POX_SUB_START      31:16
`define POX_SUB_STOP       15:0

// Command/control fields, one 8-bit slot per window
`define POX_CC_W1          31:24
`define POX_CC_W2          23:16
`define POX_CC_S1          15:8
`define POX_CC_S2          7:0
`define POX_CC_CMD         7:5
`define POX_CC_NOPOST      1
`define POX_CC_XLATE       0
`define POX_CC_MASK        32'hE7E7_E7E7

// Upper command bits of a configuration cycle
`define POX_CMD_CONFIG     3'h5

`endif

// ### pox_xlate.v
// Outbound PCI window control and address translation with Wishbone registers
`timescale 1ns/100ps
// Notes on behaviour
// [R1] PCI reset pin asserted while reset drive bit is one; reset value one.
// [R2] Reset drive bit touches only the pin, never the internal protocol core.
// [R3] Config msb force set: address msb of config commands is one, after masking.
// [R4] Config msb force clear: msb left to mask/value per window enable.
// [R5] Target post disable bit set refuses posted writes as target; clear accepts.
// [R6] Software programs target post disable before second clock of FRAME.
// [R7] Latency retry disable set suppresses automatic 16/8 rule retries as target.
// [R8] Software sets latency retry disable before clock 15 first, 7 later.
// [R9] Mask/value reads back at one address and is written at another.
// [R10] Masked upper address bits take value bits; unmasked bits pass unchanged.
// [R11] Window 1 mask, value, then window 2 mask, value in msb-first bytes.
// [R12] Replacement applies only while that window's translation enable is on.
// [R13] Subwindow start in bits 31:16; candidate when address is at or above.
// [R14] Subwindow stop in bits 15:0; hit needs address strictly below it.
// [R15] Subwindow hit uses the subwindow command/control instead of the main window.
// [R16] Both subwindows checked against any main window hit, no fixed pairing.
// [R17] Software keeps the two subwindow ranges from overlapping.
// [R18] Three-bit command drives upper command bits; lsb zero read, one write.
// [R19] Control bit 0 of each window enables its mask/value replacement.
// [R20] Subwindow and replacement only for accesses flagged as main window hits.
`include "pox_xlate_map.vh"

module pox_xlate #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // Wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [AW-1:0] wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // Access request from the memory-map decoder
  input  wire          req_valid_i,
  input  wire [31:0]   req_addr_i,
  input  wire          req_write_i,
  input  wire          req_win1_hit_i,
  input  wire          req_win2_hit_i,
  // Translated access towards the PCI core
  output reg           xl_valid_o,
  output reg  [31:0]   xl_addr_o,
  output reg  [3:0]    xl_cmd_o,
  output reg           xl_nopost_o,
  output reg  [1:0]    xl_sub_hit_o,
  // Global settings towards pins and PCI core
  output reg           pci_rst_n_o,
  output reg           tgt_post_disable_o,
  output reg           tgt_lat_retry_disable_o
);

  // Register state
  reg [31:0] gctl_q;
  reg [31:0] gctl_d;
  reg [31:0] mv_q;
  reg [31:0] mv_d;
  reg [31:0] sub1_q;
  reg [31:0] sub1_d;
  reg [31:0] sub2_q;
  reg [31:0] sub2_d;
  reg [31:0] cc_q;
  reg [31:0] cc_d;

  // Bus side
  reg [31:0] rdata_d;
  wire       wb_req;
  wire       wb_wr;

  // Translation path
  reg [7:0]  slot_d;
  reg [7:0]  mask_d;
  reg [7:0]  val_d;
  reg        main_hit_d;
  reg        s1_hit_d;
  reg        s2_hit_d;
  reg [7:0]  top_d;
  reg [31:0] addr_d;
  reg [3:0]  cmd_d;

  // Byte-lane merge of a write
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Range test of one subwindow against the upper address half
  function sub_hit;
    input [31:0] sub_v;
    input [15:0] a_hi;
    begin
      sub_hit = (a_hi >= sub_v[`POX_SUB_START]) && // R13
                (a_hi <  sub_v[`POX_SUB_STOP]);    // R14
    end
  endfunction

  // Masked replacement of the top address byte
  function [7:0] mv_apply;
    input [7:0] a_top;
    input [7:0] mask;
    input [7:0] val;
    begin
      mv_apply = (a_top & ~mask) | (val & mask); // R10
    end
  endfunction

  // Answer one cycle after the strobe; ack drops the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands on the edge where the master sees ack, request still held
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

  // Next values of software registers
  always @* begin
    gctl_d = gctl_q;
    mv_d   = mv_q;
    sub1_d = sub1_q;
    sub2_d = sub2_q;
    cc_d   = cc_q;
    if (wb_wr) begin
      case (wb_adr_i)
        `POX_OFS_GCTL: begin
          gctl_d = lane_merge(gctl_q, wb_dat_i, wb_sel_i) & `POX_GCTL_MASK;
        end
        `POX_OFS_MV_WR: begin
          mv_d = lane_merge(mv_q, wb_dat_i, wb_sel_i); // R9
        end
        `POX_OFS_SUB1: begin
          sub1_d = lane_merge(sub1_q, wb_dat_i, wb_sel_i);
        end
        `POX_OFS_SUB2: begin
          sub2_d = lane_merge(sub2_q, wb_dat_i, wb_sel_i);
        end
        `POX_OFS_CMDCTL: begin
          cc_d = lane_merge(cc_q, wb_dat_i, wb_sel_i) & `POX_CC_MASK;
        end
        default: begin
          gctl_d = gctl_q;
        end
      endcase
    end
  end

  // Read mux; write-only and unmapped locations read zero
  always @* begin
    case (wb_adr_i)
      `POX_OFS_GCTL:   rdata_d = gctl_q;
      `POX_OFS_MV_RD:  rdata_d = mv_q; // R9
      `POX_OFS_SUB1:   rdata_d = sub1_q;
      `POX_OFS_SUB2:   rdata_d = sub2_q;
      `POX_OFS_CMDCTL: rdata_d = cc_q;
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // Register file and bus answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      gctl_q   <= `POX_RST_GCTL; // R1
      mv_q     <= `POX_RST_MV;
      sub1_q   <= `POX_RST_SUB;
      sub2_q   <= `POX_RST_SUB;
      cc_q     <= `POX_RST_CMDCTL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      gctl_q   <= gctl_d;
      mv_q     <= mv_d;
      sub1_q   <= sub1_d;
      sub2_q   <= sub2_d;
      cc_q     <= cc_d;
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rdata_d;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Global settings; the pin follows the bit, nothing internal is reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      pci_rst_n_o             <= 1'b0;
      tgt_post_disable_o      <= 1'b0;
      tgt_lat_retry_disable_o <= 1'b0;
    end else begin
      pci_rst_n_o             <= ~gctl_q[`POX_GCTL_RST];    // R1 R2
      tgt_post_disable_o      <= gctl_q[`POX_GCTL_NOPOST];  // R5
      tgt_lat_retry_disable_o <= gctl_q[`POX_GCTL_NOLAT];   // R7
    end
  end

  // Window and subwindow selection
  always @* begin
    main_hit_d = req_win1_hit_i | req_win2_hit_i; // R20
    s1_hit_d   = main_hit_d && sub_hit(sub1_q, req_addr_i[31:16]); // R16
    s2_hit_d   = main_hit_d && sub_hit(sub2_q, req_addr_i[31:16]); // R16
    // Window 1 wins if the decoder flags both
    if (req_win1_hit_i) begin
      mask_d = mv_q[`POX_MV_W1_MASK]; // R11
      val_d  = mv_q[`POX_MV_W1_VAL];  // R11
      slot_d = cc_q[`POX_CC_W1];
    end else begin
      mask_d = mv_q[`POX_MV_W2_MASK]; // R11
      val_d  = mv_q[`POX_MV_W2_VAL];  // R11
      slot_d = cc_q[`POX_CC_W2];
    end
    // Overlapping subwindows are a software fault; subwindow 1 wins
    if (s1_hit_d) begin
      slot_d = cc_q[`POX_CC_S1]; // R15
    end else if (s2_hit_d) begin
      slot_d = cc_q[`POX_CC_S2]; // R15
    end
  end

  // Address and command formation
  always @* begin
    top_d = req_addr_i[31:24];
    if (main_hit_d && slot_d[`POX_CC_XLATE]) begin // R12 R19 R20
      top_d = mv_apply(req_addr_i[31:24], mask_d, val_d);
    end
    cmd_d  = {slot_d[`POX_CC_CMD], req_write_i}; // R18
    addr_d = {top_d, req_addr_i[23:0]};          // R4
    // Forced msb overrides the masked result
    if (gctl_q[`POX_GCTL_CFGMSB] && (slot_d[`POX_CC_CMD] == `POX_CMD_CONFIG)) begin
      addr_d[31] = 1'b1; // R3
    end
  end

  // Registered translated access; unflagged requests are dropped, valid clears, the other outputs hold
  always @(posedge clk_i) begin
    if (rst_i) begin
      xl_valid_o   <= 1'b0;
      xl_addr_o    <= 32'h0000_0000;
      xl_cmd_o     <= 4'h0;
      xl_nopost_o  <= 1'b0;
      xl_sub_hit_o <= 2'h0;
    end else begin
      xl_valid_o <= req_valid_i & main_hit_d; // R20
      if (req_valid_i && main_hit_d) begin
        xl_addr_o    <= addr_d;
        xl_cmd_o     <= cmd_d;
        xl_nopost_o  <= slot_d[`POX_CC_NOPOST];
        xl_sub_hit_o <= {s2_hit_d & ~s1_hit_d, s1_hit_d};
      end
    end
  end

endmodule // pox_xlate

// ### pox_xlate_properties.sv
// Port checker of the outbound window block
`timescale 1ns/100ps
module pox_xlate_properties #(parameter AW = 12) (
  // Clock, reset, register bus
  input logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input logic [AW-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i, wb_dat_o,
  // Translation
  input logic req_valid_i, req_write_i, req_win1_hit_i, req_win2_hit_i,
  input logic [31:0] req_addr_i, xl_addr_o,
  input logic xl_valid_o, xl_nopost_o,
  input logic [3:0] xl_cmd_o,
  input logic [1:0] xl_sub_hit_o,
  // Settings
  input logic pci_rst_n_o, tgt_post_disable_o, tgt_lat_retry_disable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  a_xl_on_hit: assert property (req_valid_i && (req_win1_hit_i || req_win2_hit_i) |=> xl_valid_o)
    else $error("hit not passed");
  a_xl_no_hit: assert property (!(req_valid_i && (req_win1_hit_i || req_win2_hit_i)) |=> !xl_valid_o)
    else $error("spurious access");
  a_cmd_lsb_dir: assert property (xl_valid_o |-> xl_cmd_o[0] == $past(req_write_i)) else $error("cmd lsb");
  a_low_addr_pass: assert property (xl_valid_o |-> xl_addr_o[23:0] == $past(req_addr_i[23:0]))
    else $error("low address altered");
  a_settings_on_write: assert property ($changed({pci_rst_n_o, tgt_post_disable_o, tgt_lat_retry_disable_o})
    |-> $past(wb_ack_o & wb_we_i) || $past(wb_ack_o & wb_we_i, 2)) else $error("setting moved alone");
endmodule // pox_xlate_properties
bind pox_xlate pox_xlate_properties #(.AW(AW)) u_props (.*);

// ### pox_pci_target.sv
// Far-side PCI core model recording translated accesses
`timescale 1ns/100ps
module pox_pci_target (
  // Clock and address phase
  input  logic        clk_i,
  input  logic        valid_i,
  input  logic [31:0] addr_i,
  input  logic [3:0]  cmd_i,
  input  logic [1:0]  sub_i,
  // Last access and count
  output logic [31:0] seen_addr_o,
  output logic [3:0]  seen_cmd_o,
  output logic [1:0]  seen_sub_o,
  output logic [7:0]  seen_cnt_o
);
  initial seen_cnt_o = 8'h00;
  // Taken on the pulse only; held fields between pulses are not trusted
  always @(posedge clk_i) begin
    if (valid_i) begin
      seen_addr_o <= addr_i;
      seen_cmd_o  <= cmd_i;
      seen_sub_o  <= sub_i;
      seen_cnt_o  <= seen_cnt_o + 8'h01;
    end
  end
endmodule // pox_pci_target

// ### pox_xlate_tb.sv
// Self-checking bench of the outbound window block
`timescale 1ns/100ps
`include "pox_xlate_map.vh"
module pox_xlate_tb;
  typedef struct packed {logic [31:0] a, ea; logic [2:0] m; logic [3:0] ec; logic [1:0] es;} pox_row_t;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, req_valid_i = 0, req_write_i = 0;
  logic req_win1_hit_i = 0, req_win2_hit_i = 0, wb_ack_o, xl_valid_o, xl_nopost_o;
  logic pci_rst_n_o, tgt_post_disable_o, tgt_lat_retry_disable_o;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0]  wb_sel_i = 4'hF, xl_cmd_o, s_cmd;
  logic [31:0] wb_dat_i = 32'h0, req_addr_i = 32'h0, wb_dat_o, xl_addr_o, s_addr, r;
  logic [1:0]  xl_sub_hit_o, s_sub;
  logic [7:0]  s_cnt, n_exp = 8'h00;
  int bad_count = 0, checks_done = 0, cyc_n = 0;
  pox_row_t rows [9] = '{
    '{32'h5566_7788, 32'hA566_7788, 3'h2, 4'h6, 2'h0}, '{32'h0012_3456, 32'hA012_3456, 3'h6, 4'h7, 2'h0},
    '{32'h8000_0004, 32'h8000_0004, 3'h1, 4'hA, 2'h0}, '{32'h1000_0000, 32'h1000_0000, 3'h1, 4'hC, 2'h1},
    '{32'h1FFF_FFFC, 32'h1FFF_FFFC, 3'h6, 4'hD, 2'h1}, '{32'h2000_0000, 32'hA000_0000, 3'h2, 4'h6, 2'h0},
    '{32'h3000_0010, 32'h3000_0010, 3'h5, 4'hF, 2'h2}, '{32'h0000_000C, 32'h0000_000C, 3'h1, 4'hA, 2'h0},
    '{32'h1500_0000, 32'h0, 3'h0, 4'h0, 2'h0}};
  pox_xlate dut (.*);
  pox_pci_target u_pci (.clk_i, .valid_i(xl_valid_o), .addr_i(xl_addr_o), .cmd_i(xl_cmd_o), .sub_i(xl_sub_hit_o),
    .seen_addr_o(s_addr), .seen_cmd_o(s_cmd), .seen_sub_o(s_sub), .seen_cnt_o(s_cnt));
  always #2 clk_i = ~clk_i;
  task stop_test();
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the roughly 110 cycles used
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task rd(input logic [11:0] ad, input logic [31:0] e);
    bus(1'h0, ad, 32'h0);
    chk(r, e);
  endtask
  task xreq(input pox_row_t x);
    @(posedge clk_i);
    req_valid_i <= 1'h1;
    {req_write_i, req_win1_hit_i, req_win2_hit_i} <= x.m;
    req_addr_i <= x.a;
    @(posedge clk_i);
    req_valid_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    #1;
    n_exp = n_exp + (x.m[1] | x.m[0]);
    chk(s_cnt, n_exp);
    if (x.m[1] | x.m[0]) begin
      chk(s_addr, x.ea);
      chk({s_cmd, 2'h0, s_sub}, {x.ec, 2'h0, x.es});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    chk(pci_rst_n_o, 32'h0);
    rd(`POX_OFS_GCTL, `POX_RST_GCTL);
    bus(1'h1, `POX_OFS_MV_WR, 32'hF0A5_0F3C);
    bus(1'h1, `POX_OFS_MV_RD, 32'h0);
    rd(`POX_OFS_MV_RD, 32'hF0A5_0F3C);
    rd(`POX_OFS_MV_WR, 32'h0);
    rd(12'hD60, 32'h0);
    bus(1'h1, `POX_OFS_SUB1, 32'h1000_2000);
    bus(1'h1, `POX_OFS_SUB2, 32'h3000_4000);
    bus(1'h1, `POX_OFS_CMDCTL, 32'h61A0_C0E0);
    rd(`POX_OFS_CMDCTL, 32'h61A0_C0E0);
    foreach (rows[i]) xreq(rows[i]);
    chk(xl_nopost_o, 32'h0);
    bus(1'h1, `POX_OFS_GCTL, 32'h0400_0000);
    rd(`POX_OFS_GCTL, 32'h0400_0000);
    chk(pci_rst_n_o, 32'h1);
    xreq('{32'h0000_000C, 32'h8000_000C, 3'h1, 4'hA, 2'h0});
    bus(1'h1, `POX_OFS_GCTL, 32'h0300_0000);
    rd(`POX_OFS_GCTL, 32'h0300_0000);
    chk({tgt_post_disable_o, tgt_lat_retry_disable_o}, 32'h3);
    bus(1'h1, `POX_OFS_GCTL, 32'h0);
    rd(`POX_OFS_GCTL, 32'h0);
    chk({tgt_post_disable_o, tgt_lat_retry_disable_o}, 32'h0);
    bus(1'h1, `POX_OFS_CMDCTL, 32'h61A2_C0E0);
    xreq('{32'h0000_000C, 32'h0000_000C, 3'h1, 4'hA, 2'h0});
    chk(xl_nopost_o, 32'h1);
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    chk(pci_rst_n_o, 32'h0);
    rd(`POX_OFS_MV_RD, `POX_RST_MV);
    stop_test();
  end
endmodule // pox_xlate_tb
